// ==== verilog/dpa_pkg.sv ====
// package for the dual-port ram port host controller
package dpa_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ARB_SETUP_NS = 5;
    // least time rounds up
    localparam int ARB_SETUP_CYC =
        (ARB_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_NS = 100;
    localparam int ACCESS_CYC =
        (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_HOLD_NS = 20;
    localparam int WRITE_HOLD_CYC =
        (WRITE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // flops between a ram pin and the logic that reads it
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [2:0] {
        DPA_IDLE = 3'h0,
        DPA_SETUP = 3'h1,
        DPA_WAIT = 3'h3,
        DPA_STROBE = 3'h2,
        DPA_HOLD = 3'h6,
        DPA_DONE = 3'h7
    } dpa_state_type;

    // user request
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpa_req_type;

    // pins driven toward one ram port
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic read_write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic data_oe_n;
    } dpa_pins_type;
endpackage : dpa_pkg

// ==== verilog/dpa_port_host.sv ====
// host controller that drives one port of the dual-port ram
`timescale 1ns/10ps
// Notes on behaviour
// - host holds address and select before write pulse starts
// - host stalls on busy until released, then completes
// - one master arbitrates; slaves take its busy as inhibit
// - busy lines may be ORed to flag illegal access
// - earlier port settles 5 ns ahead to surely win
module dpa_port_host #(
    parameter int SETUP_CYC = dpa_pkg::ARB_SETUP_CYC,
    parameter int ACCESS_CYC = dpa_pkg::ACCESS_CYC,
    parameter int HOLD_CYC = dpa_pkg::WRITE_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input dpa_pkg::dpa_req_type req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [dpa_pkg::DATA_W-1:0] rsp_data,
    output logic contention_seen,
    output dpa_pkg::dpa_pins_type pins,
    input wire logic [dpa_pkg::DATA_W-1:0] port_data_bus_in,
    input wire logic contention_flag_n
);
    import dpa_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic busy_s1_r;
    logic busy_s2_r;
    logic [DATA_W-1:0] din_s1_r;
    logic [DATA_W-1:0] din_s2_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_s1_r <= 1'b1;
            busy_s2_r <= 1'b1;
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
        end else begin
            // one busy pin only: a single master arbitrates for the word
            busy_s1_r <= contention_flag_n;
            busy_s2_r <= busy_s1_r;
            din_s1_r <= port_data_bus_in;
            din_s2_r <= din_s1_r;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    dpa_state_type state_r;
    dpa_state_type state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    dpa_req_type hold_r;
    dpa_req_type hold_nxt;
    dpa_pins_type pins_r;
    dpa_pins_type pins_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic rsp_r;
    logic seen_r;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? CNT_ONE : CNT_W'(n);
    endfunction : cyc

    // park the strobes; select and address are left as they are
    function automatic dpa_pins_type strobes_off(input dpa_pins_type p);
        strobes_off = p;
        strobes_off.read_write = 1'b1;
        strobes_off.out_en_n = 1'b1;
        strobes_off.data_oe_n = 1'b1;
    endfunction : strobes_off

    // ************************************************************
    // request intake and phase lengths
    // ************************************************************
    wire busy_low = ~busy_s2_r;
    wire cnt_done = (cnt_r == CNT_ONE) || (cnt_r == CNT_ZERO);
    wire take = (state_r == DPA_IDLE) && req_valid;
    wire strobe_end = (state_r == DPA_STROBE) && !busy_low && cnt_done;
    wire hold_end = (state_r == DPA_HOLD) && cnt_done;
    // setup also spans the busy synchroniser, so a busy raised by our
    // own select is seen before any strobe, whatever the wait length
    wire [CNT_W-1:0] setup_len = cyc(SETUP_CYC + SYNC_STAGES);
    // strobe long enough for read data to pass the synchroniser
    wire [CNT_W-1:0] strobe_len =
        cyc((ACCESS_CYC > SYNC_STAGES) ? ACCESS_CYC : SYNC_STAGES + 1);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_done ? cnt_r : cnt_r - CNT_ONE;
        hold_nxt = hold_r;
        pins_nxt = pins_r;
        case (state_r)
            DPA_IDLE: begin
                // deselected: port floats and sleeps
                pins_nxt = strobes_off(pins_r);
                pins_nxt.chip_sel_n = 1'b1;
                if (take) begin
                    hold_nxt = req;
                    // any of the full address range may be used
                    pins_nxt.addr = req.addr;
                    pins_nxt.chip_sel_n = 1'b0;
                    pins_nxt.data_out = req.wdata;
                    cnt_nxt = setup_len;
                    state_nxt = DPA_SETUP;
                end
            end
            DPA_SETUP: begin
                // settle address and select, let busy propagate
                // through the synchroniser before any strobe
                if (cnt_done) begin
                    cnt_nxt = cyc(ACCESS_CYC);
                    state_nxt = DPA_WAIT;
                end
            end
            DPA_WAIT: begin
                // stall while the far port owns this location
                if (busy_low) begin
                    cnt_nxt = cyc(ACCESS_CYC);
                end else if (cnt_done) begin
                    cnt_nxt = strobe_len;
                    state_nxt = DPA_STROBE;
                    pins_nxt.read_write = ~hold_r.write;
                    pins_nxt.out_en_n = hold_r.write;
                    pins_nxt.data_oe_n = ~hold_r.write;
                end
            end
            DPA_STROBE: begin
                // busy mid-strobe means the access was inhibited:
                // drop the strobe and retry after release
                if (busy_low) begin
                    pins_nxt = strobes_off(pins_r);
                    cnt_nxt = cyc(ACCESS_CYC);
                    state_nxt = DPA_WAIT;
                end else if (cnt_done) begin
                    pins_nxt.read_write = 1'b1;
                    pins_nxt.out_en_n = 1'b1;
                    cnt_nxt = cyc(HOLD_CYC);
                    state_nxt = DPA_HOLD;
                end
            end
            DPA_HOLD: begin
                if (cnt_done) begin
                    pins_nxt.data_oe_n = 1'b1;
                    pins_nxt.chip_sel_n = 1'b1;
                    state_nxt = DPA_DONE;
                end
            end
            DPA_DONE: begin
                // one parked clock, then ready for the next request
                state_nxt = DPA_IDLE;
            end
            default: begin
                state_nxt = DPA_IDLE;
            end
        endcase
    end

    // ************************************************************
    // response and contention flag
    // ************************************************************
    // read data sampled at strobe end from the synchronised bus
    wire read_end = strobe_end && !hold_r.write;
    // per-port busy term; the system ORs both ports into one flag
    wire flag_hit = (state_r != DPA_IDLE) && busy_low;

    // ************************************************************
    // state and pin registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= DPA_IDLE;
            cnt_r <= CNT_ZERO;
            hold_r <= '0;
            pins_r <= '{chip_sel_n: 1'b1, out_en_n: 1'b1,
                read_write: 1'b1, addr: '0, data_out: '0,
                data_oe_n: 1'b1};
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            pins_r <= pins_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
            rsp_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            if (read_end) begin
                rdata_r <= din_s2_r;
            end
            rsp_r <= hold_end;
            seen_r <= flag_hit;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    assign req_ready = (state_r == DPA_IDLE);
    assign rsp_valid = rsp_r;
    assign rsp_data = rdata_r;
    assign contention_seen = seen_r;
    assign pins = pins_r;
endmodule : dpa_port_host

// ==== test/dpa_port_host_props.sv ====
// assertions on the pins of the ram port host controller
`timescale 1ns/10ps
module dpa_host_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input dpa_pkg::dpa_req_type req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic contention_seen,
    input dpa_pkg::dpa_pins_type pins,
    input wire logic contention_flag_n
);
    import dpa_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ************************************************************
    // sequences
    // ************************************************************
    sequence taken_s;
        req_valid && req_ready;
    endsequence
    // five samples cover the two-flop synchroniser and the state change
    sequence busy_held_s;
        !contention_flag_n [*5];
    endsequence
    // three samples carry busy through the synchroniser to the flag
    sequence busy_seen_s;
        !contention_flag_n [*3] ##0 !req_ready;
    endsequence
    // ************************************************************
    // properties
    // ************************************************************
    reset_idle_a: assert property (disable iff (1'b0) rst |=>
        pins.chip_sel_n && pins.read_write && pins.data_oe_n)
        else $error("port active after reset");
    take_sel_a: assert property (taken_s |=>
        !pins.chip_sel_n && pins.addr == $past(req.addr))
        else $error("request not presented on port");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    desel_float_a: assert property (pins.chip_sel_n |->
        pins.data_oe_n && pins.out_en_n && pins.read_write)
        else $error("deselected port still active");
    read_float_a: assert property (!pins.out_en_n |->
        pins.data_oe_n && pins.read_write)
        else $error("host drives bus during read");
    write_sel_a: assert property (!pins.read_write |-> !pins.chip_sel_n)
        else $error("write strobe without select");
    strobe_setup_a: assert property ($fell(pins.read_write) |->
        $past(!pins.chip_sel_n) && $stable(pins.addr))
        else $error("write pulse before address settled");
    busy_stall_a: assert property (busy_held_s |->
        pins.read_write && pins.out_en_n)
        else $error("strobe kept while busy low");
    flag_track_a: assert property (busy_seen_s |=> contention_seen)
        else $error("contention flag missed busy");
endmodule : dpa_host_chk
bind dpa_port_host dpa_host_chk u_chk (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins),
    .contention_seen(contention_seen),
    .contention_flag_n(contention_flag_n)
);

// ==== test/dpa_ram_model.sv ====
// behavioural model of one ram port and its busy arbiter
`timescale 1ns/10ps
module dpa_ram_model (
    input wire logic core_clk,
    input dpa_pkg::dpa_pins_type pins,
    input wire logic other_sel_n,
    input wire logic [dpa_pkg::ADDR_W-1:0] other_addr,
    output logic [dpa_pkg::DATA_W-1:0] bus,
    output logic contention_flag_n
);
    import dpa_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_r = 8'h00;
    logic lose_r = 1'b0;
    logic sel_d_r = 1'b1;
    wire both_w = !pins.chip_sel_n && !other_sel_n;
    wire match_w = both_w && pins.addr == other_addr;
    wire rd_w = !pins.chip_sel_n && pins.read_write && !pins.out_en_n;
    // later port loses; never both low since only this side is modelled
    wire lose_w = match_w && (lose_r || sel_d_r);
    assign contention_flag_n = !lose_w;
    always_comb begin
        if (!pins.data_oe_n)
            bus = pins.data_out;
        else if (rd_w)
            bus = contention_flag_n ? mem[pins.addr] : ~mem[pins.addr];
        else
            bus = ~last_r;
    end
    always @(posedge core_clk) begin
        last_r <= bus;
        sel_d_r <= pins.chip_sel_n;
        lose_r <= lose_w;
        if (!pins.chip_sel_n && !pins.read_write && contention_flag_n)
            mem[pins.addr] <= bus;
    end
endmodule : dpa_ram_model

// ==== test/tb_top.sv ====
// self-checking bench for the ram port host controller
`timescale 1ns/10ps
module tb_top;
    import dpa_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic osel_n = 1'b1;
    logic req_ready, rsp_valid, contention_seen, flag_n;
    logic [ADDR_W-1:0] oaddr = '0;
    logic [DATA_W-1:0] rsp_data, bus;
    dpa_req_type req = '0;
    dpa_pins_type pins;
    int n_errors = 0;
    int n_checks = 0;
    initial forever #2.5 core_clk = ~core_clk;
    dpa_port_host #(.SETUP_CYC(1), .ACCESS_CYC(4), .HOLD_CYC(1)) dut (
        .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .contention_seen(contention_seen), .pins(pins),
        .port_data_bus_in(bus), .contention_flag_n(flag_n));
    dpa_ram_model ram (.core_clk(core_clk), .pins(pins),
        .other_sel_n(osel_n), .other_addr(oaddr), .bus(bus),
        .contention_flag_n(flag_n));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // one access; busy reports whether contention was seen meanwhile
    task automatic access(input logic wr, input logic [10:0] a,
            input logic [7:0] d, output logic [7:0] q, output logic busy);
        int i = 0;
        busy = 1'b0;
        req = '{wr, a, d};
        req_valid = 1'b1;
        while (!req_ready && i < 400) begin
            @(posedge core_clk);
            #1 i++;
        end
        if (i == 400) begin
            n_errors++;
            wrap_up();
        end
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1 busy |= contention_seen;
        end
        if (i == 400) begin
            n_errors++;
            wrap_up();
        end
        q = rsp_data;
    endtask : access
    task automatic t_rw;
        logic [10:0] ad [3] = '{11'h000, 11'h7FF, 11'h2AA};
        logic [7:0] q;
        logic b;
        for (int k = 0; k < 3; k++) begin
            access(1'b1, ad[k], 8'hA5 ^ 8'(k), q, b);
            access(1'b0, ad[k], 8'h00, q, b);
            check("read back", q, 8'hA5 ^ 8'(k));
        end
    endtask : t_rw
    task automatic t_busy;
        logic [7:0] q;
        logic b;
        oaddr = 11'h055;
        for (int w = 1; w >= 0; w--) begin
            osel_n = 1'b0;
            fork
                access(w[0], 11'h055, 8'h3C, q, b);
                begin
                    repeat (30) @(posedge core_clk);
                    #1 osel_n = 1'b1;
                end
            join
            check("busy seen", {7'h00, b}, 8'h01);
        end
        check("stalled write", q, 8'h3C);
        oaddr = 11'h056;
        osel_n = 1'b0;
        access(1'b1, 11'h055, 8'h77, q, b);
        check("no match busy", {7'h00, b}, 8'h00);
        osel_n = 1'b1;
    endtask : t_busy
    initial begin
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        t_rw();
        t_busy();
        wrap_up();
    end
endmodule : tb_top
